// ### src/utp_map.svh
`ifndef UTP_MAP_SVH
`define UTP_MAP_SVH

// Register byte offsets
`define UTP_OFF_CTRL 12'h000
`define UTP_OFF_PICKUP 12'h004
`define UTP_OFF_RATIO 12'h008
`define UTP_OFF_FIXED_DELAY 12'h00C
`define UTP_OFF_K 12'h010
`define UTP_OFF_SCALE 12'h014
`define UTP_OFF_DECAY 12'h018
`define UTP_OFF_THETA_MAX 12'h01C
`define UTP_OFF_STATUS 12'h020
`define UTP_OFF_INT_STATUS 12'h024
`define UTP_OFF_INT_MASK 12'h028
`define UTP_OFF_CMD 12'h02C

// Control field positions
`define UTP_CTRL_RATIO_EN 0
`define UTP_CTRL_INVERSE 1
`define UTP_CTRL_ROT_ACB 2

// Interrupt bit positions
`define UTP_INT_PICKUP 0
`define UTP_INT_TRIP 1
`define UTP_INT_DROPOUT 2

// Reset values
`define UTP_RST_CTRL 3'h0
`define UTP_RST_PICKUP 16'h0100
`define UTP_RST_RATIO 8'h02
`define UTP_RST_FIXED_DELAY 32'h0000_1000
`define UTP_RST_K 32'h0001_0000
`define UTP_RST_SCALE 16'h0100
`define UTP_RST_DECAY 16'hFF00
`define UTP_RST_THETA_MAX 32'h0001_0000

// Arithmetic constants
`define UTP_SIN60 32'sh0000_6EDA
`define UTP_PCT2 64'h0000_0000_0000_2710
`define UTP_HYST 64'h0000_0000_0000_24C1
`define UTP_CUTOFF 64'h0000_0000_0000_0064

`endif

// ### src/utp_pkg.sv
package utp_pkg;

   typedef struct packed {
      logic signed [19:0] re;
      logic signed [19:0] im;
   } utp_cplx_t;

   typedef enum logic [2:0] {
      UTP_IDLE = 3'b001,
      UTP_PICKED = 3'b010,
      UTP_TRIPPED = 3'b100
   } utp_state_t;

endpackage : utp_pkg

// ### src/utp_thermal_if.sv
interface utp_thermal_if;
   logic sample;
   logic heating;
   logic clear;
   logic [41:0] i2sq;
   logic [15:0] scale;
   logic [15:0] decay;
   logic [31:0] theta_max;
   logic [47:0] theta;

   modport core (output sample, output heating, output clear, output i2sq, output scale, output decay,
      output theta_max, input theta);
   modport calc (input sample, input heating, input clear, input i2sq, input scale, input decay,
      input theta_max, output theta);
endinterface : utp_thermal_if

// ### src/utp_thermal.sv
`include "utp_map.svh"

module utp_thermal (
   input wire logic clk_sys,
   input wire logic reset,
   utp_thermal_if.calc th
);

   logic [47:0] theta_r;
   logic [47:0] theta_nxt;

   assign th.theta = theta_r;

   always_comb begin
      logic [57:0] heat_prod;
      logic [48:0] heat_sum;
      logic [63:0] cool_prod;
      logic [47:0] cooled;
      logic [63:0] cut_lhs;
      heat_prod = 58'(th.i2sq) * 58'(th.scale);
      heat_sum = 49'(theta_r) + 49'(heat_prod[57:16]);
      cool_prod = 64'(theta_r) * 64'(th.decay);
      cooled = cool_prod[63:16];
      cut_lhs = 64'(cooled) * `UTP_CUTOFF;
      theta_nxt = theta_r;
      if (th.clear) begin
         theta_nxt = '0;
      end else if (th.sample) begin
         if (th.heating) begin
            // Saturate rather than wrap; wrap would fake a cold object
            theta_nxt = heat_sum[48] ? '1 : heat_sum[47:0];
         end else if (cut_lhs < {16'h0000, th.theta_max, 16'h0000}) begin
            theta_nxt = '0;
         end else begin
            theta_nxt = cooled;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         theta_r <= '0;
      end else begin
         theta_r <= theta_nxt;
      end
   end

endmodule : utp_thermal

// ### src/utp_top.sv
`include "utp_map.svh"

// Behaviour
// - Above pickup threshold, thermal value grows by scaled squared negative-sequence current.
// - Heating starts from the value left by cooling, or zero after full decay.
// - Below threshold, thermal value decays exponentially with the configured cooling factor.
// - Cooling ends and value is forced to zero under one hundredth of maximum.
// - Residual thermal value shortens the inverse trip delay.
// - Thermal value is internal only; no register or port reads it.
// - Threshold pickup releases only at or below 0.97 of the threshold.
// - Ratio pickup releases once ratio falls more than one point below its setting.
// - One missing phase gives a negative-sequence magnitude of one third.
// - Sequence components follow the configured rotation; reversed rotation gives full magnitude.
// - Ratio setting down to 2 percent, threshold down to 0.01 nominal.
// - Reset command clears the element and timers, and signals other overcurrent functions.
// - Trip when threshold and enabled ratio conditions hold for the selected delay.
// - Selector chooses fixed delay or thermally calculated inverse delay.
// - Cold inverse delay is capability constant over squared current minus squared threshold.
module utp_top #(
   parameter int IN_W = 16
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sample_valid,
   input wire logic signed [IN_W-1:0] ph_a_re,
   input wire logic signed [IN_W-1:0] ph_a_im,
   input wire logic signed [IN_W-1:0] ph_b_re,
   input wire logic signed [IN_W-1:0] ph_b_im,
   input wire logic signed [IN_W-1:0] ph_c_re,
   input wire logic signed [IN_W-1:0] ph_c_im,
   output logic pickup,
   output logic trip,
   output logic prot_reset_pulse,
   output logic irq
);

   // Rotate by 120 degrees; conj selects 240 degrees
   function automatic utp_pkg::utp_cplx_t rot120(input utp_pkg::utp_cplx_t x, input logic conj);
      utp_pkg::utp_cplx_t r;
      logic signed [51:0] sre;
      logic signed [51:0] sim;
      sre = 52'(x.re) * 52'(`UTP_SIN60);
      sim = 52'(x.im) * 52'(`UTP_SIN60);
      if (conj) begin
         r.re = 20'(-(x.re >>> 1) + (sim >>> 15));
         r.im = 20'(-(sre >>> 15) - (x.im >>> 1));
      end else begin
         r.re = 20'(-(x.re >>> 1) - (sim >>> 15));
         r.im = 20'((sre >>> 15) - (x.im >>> 1));
      end
      return r;
   endfunction : rot120

   // Squared magnitude of a three-term sum, divided by nine
   function automatic logic [41:0] mag2_third(input utp_pkg::utp_cplx_t a, input utp_pkg::utp_cplx_t b,
         input utp_pkg::utp_cplx_t c);
      logic signed [21:0] sre;
      logic signed [21:0] sim;
      logic [43:0] sq;
      sre = 22'(a.re) + 22'(b.re) + 22'(c.re);
      sim = 22'(a.im) + 22'(b.im) + 22'(c.im);
      sq = 44'(sre * sre) + 44'(sim * sim);
      return 42'(sq / 44'd9);
   endfunction : mag2_third

   logic [2:0] ctrl_r, ctrl_nxt;
   logic [15:0] pickup_thr_r, pickup_thr_nxt;
   logic [7:0] ratio_r, ratio_nxt;
   logic [31:0] fixed_delay_r, fixed_delay_nxt;
   logic [31:0] k_r, k_nxt;
   logic [15:0] scale_r, scale_nxt;
   logic [15:0] decay_r, decay_nxt;
   logic [31:0] theta_max_r, theta_max_nxt;
   logic [2:0] int_status_r, int_status_nxt;
   logic [2:0] int_mask_r, int_mask_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pslverr_r, pslverr_nxt;
   logic cmd_reset_r, cmd_reset_nxt;

   logic [41:0] i2sq_r, i2sq_nxt;
   logic [41:0] i1sq_r, i1sq_nxt;
   logic meas_valid_r, meas_valid_nxt;

   utp_pkg::utp_state_t state_r, state_nxt;
   logic [31:0] delay_cnt_r, delay_cnt_nxt;
   logic [47:0] inv_acc_r, inv_acc_nxt;

   logic setup, access, wr_en, rd_done;
   logic [2:0] events;
   logic heating;
   logic thr_above, thr_hold, ratio_above, ratio_hold;

   utp_thermal_if th ();

   utp_thermal u_thermal (
      .clk_sys(clk_sys),
      .reset(reset),
      .th(th)
   );

   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign wr_en = access & pwrite;
   assign rd_done = access & ~pwrite;
   // Single-cycle access phase; read data is latched in the setup cycle
   assign pready = 1'b1;
   assign prdata = prdata_r;
   assign pslverr = pslverr_r;
   assign prot_reset_pulse = cmd_reset_r;
   assign pickup = state_r != utp_pkg::UTP_IDLE;
   assign trip = state_r == utp_pkg::UTP_TRIPPED;
   assign irq = |(int_status_r & int_mask_r);

   // Register file; the thermal value has no address on purpose
   always_comb begin
      logic mapped;
      mapped = 1'b1;
      ctrl_nxt = ctrl_r;
      pickup_thr_nxt = pickup_thr_r;
      ratio_nxt = ratio_r;
      fixed_delay_nxt = fixed_delay_r;
      k_nxt = k_r;
      scale_nxt = scale_r;
      decay_nxt = decay_r;
      theta_max_nxt = theta_max_r;
      int_mask_nxt = int_mask_r;
      cmd_reset_nxt = 1'b0;
      prdata_nxt = prdata_r;
      pslverr_nxt = pslverr_r;
      int_status_nxt = int_status_r;
      if (paddr == `UTP_OFF_CTRL) begin
         prdata_nxt = {29'h0, ctrl_r};
         if (wr_en) ctrl_nxt = pwdata[2:0];
      end else if (paddr == `UTP_OFF_PICKUP) begin
         prdata_nxt = {16'h0000, pickup_thr_r};
         if (wr_en) pickup_thr_nxt = pwdata[15:0];
      end else if (paddr == `UTP_OFF_RATIO) begin
         prdata_nxt = {24'h00_0000, ratio_r};
         if (wr_en) ratio_nxt = pwdata[7:0];
      end else if (paddr == `UTP_OFF_FIXED_DELAY) begin
         prdata_nxt = fixed_delay_r;
         if (wr_en) fixed_delay_nxt = pwdata;
      end else if (paddr == `UTP_OFF_K) begin
         prdata_nxt = k_r;
         if (wr_en) k_nxt = pwdata;
      end else if (paddr == `UTP_OFF_SCALE) begin
         prdata_nxt = {16'h0000, scale_r};
         if (wr_en) scale_nxt = pwdata[15:0];
      end else if (paddr == `UTP_OFF_DECAY) begin
         prdata_nxt = {16'h0000, decay_r};
         if (wr_en) decay_nxt = pwdata[15:0];
      end else if (paddr == `UTP_OFF_THETA_MAX) begin
         prdata_nxt = theta_max_r;
         if (wr_en) theta_max_nxt = pwdata;
      end else if (paddr == `UTP_OFF_STATUS) begin
         prdata_nxt = {29'h0, heating, trip, pickup};
      end else if (paddr == `UTP_OFF_INT_STATUS) begin
         prdata_nxt = {29'h0, int_status_r};
         // Clear only what the latched word reported; a later event survives
         if (rd_done) int_status_nxt = int_status_r & ~prdata_r[2:0];
      end else if (paddr == `UTP_OFF_INT_MASK) begin
         prdata_nxt = {29'h0, int_mask_r};
         if (wr_en) int_mask_nxt = pwdata[2:0];
      end else if (paddr == `UTP_OFF_CMD) begin
         prdata_nxt = 32'h0000_0000;
         if (wr_en) cmd_reset_nxt = pwdata[0];
      end else begin
         mapped = 1'b0;
         prdata_nxt = 32'h0000_0000;
      end
      if (!setup) begin
         prdata_nxt = prdata_r;
      end else begin
         pslverr_nxt = ~mapped;
      end
      // A new event beats the read-clear in the same cycle
      int_status_nxt = int_status_nxt | events;
   end

   // Sequence components, registered one cycle after each sample
   always_comb begin
      utp_pkg::utp_cplx_t a, b, c;
      a.re = 20'(ph_a_re);
      a.im = 20'(ph_a_im);
      b.re = 20'(ctrl_r[`UTP_CTRL_ROT_ACB] ? ph_c_re : ph_b_re);
      b.im = 20'(ctrl_r[`UTP_CTRL_ROT_ACB] ? ph_c_im : ph_b_im);
      c.re = 20'(ctrl_r[`UTP_CTRL_ROT_ACB] ? ph_b_re : ph_c_re);
      c.im = 20'(ctrl_r[`UTP_CTRL_ROT_ACB] ? ph_b_im : ph_c_im);
      meas_valid_nxt = sample_valid;
      i2sq_nxt = i2sq_r;
      i1sq_nxt = i1sq_r;
      if (sample_valid) begin
         i2sq_nxt = mag2_third(a, rot120(b, 1'b1), rot120(c, 1'b0));
         i1sq_nxt = mag2_third(a, rot120(b, 1'b0), rot120(c, 1'b1));
      end
   end

   // Pickup and hysteresis compares, all on squared magnitudes
   always_comb begin
      logic [63:0] thrsq, i2_pct, r_sq, r1_sq;
      logic [7:0] r_low;
      thrsq = 64'(pickup_thr_r) * 64'(pickup_thr_r);
      i2_pct = 64'(i2sq_r) * `UTP_PCT2;
      r_low = (ratio_r == 8'h00) ? 8'h00 : ratio_r - 8'h01;
      r_sq = 64'(ratio_r) * 64'(ratio_r) * 64'(i1sq_r);
      r1_sq = 64'(r_low) * 64'(r_low) * 64'(i1sq_r);
      thr_above = 64'(i2sq_r) > thrsq;
      thr_hold = i2_pct > (thrsq * `UTP_HYST);
      ratio_above = ~ctrl_r[`UTP_CTRL_RATIO_EN] | (i2_pct > r_sq);
      ratio_hold = ~ctrl_r[`UTP_CTRL_RATIO_EN] | (i2_pct >= r1_sq);
   end

   assign heating = thr_above;
   assign th.sample = meas_valid_r;
   assign th.heating = heating;
   assign th.clear = cmd_reset_r;
   assign th.i2sq = i2sq_r;
   assign th.scale = scale_r;
   assign th.decay = decay_r;
   assign th.theta_max = theta_max_r;

   // Pickup, delay and trip
   always_comb begin
      logic [63:0] excess;
      logic [48:0] inv_sum;
      logic elapsed;
      elapsed = 1'b0;
      excess = 64'(i2sq_r) - 64'(pickup_thr_r) * 64'(pickup_thr_r);
      inv_sum = 49'(inv_acc_r) + 49'(th.theta);
      if (ctrl_r[`UTP_CTRL_INVERSE]) begin
         elapsed = inv_sum >= 49'({k_r, 16'h0000});
      end else begin
         elapsed = delay_cnt_r >= fixed_delay_r;
      end
      state_nxt = state_r;
      delay_cnt_nxt = delay_cnt_r;
      inv_acc_nxt = inv_acc_r;
      events = 3'h0;
      if (cmd_reset_r) begin
         state_nxt = utp_pkg::UTP_IDLE;
         delay_cnt_nxt = 32'h0000_0000;
         inv_acc_nxt = '0;
      end else if (meas_valid_r) begin
         case (state_r)
            utp_pkg::UTP_IDLE: begin
               delay_cnt_nxt = 32'h0000_0000;
               inv_acc_nxt = '0;
               if (thr_above && ratio_above) begin
                  state_nxt = utp_pkg::UTP_PICKED;
                  events[`UTP_INT_PICKUP] = 1'b1;
               end
            end
            utp_pkg::UTP_PICKED: begin
               if (!(thr_hold && ratio_hold)) begin
                  state_nxt = utp_pkg::UTP_IDLE;
                  events[`UTP_INT_DROPOUT] = 1'b1;
               end else if (elapsed) begin
                  state_nxt = utp_pkg::UTP_TRIPPED;
                  events[`UTP_INT_TRIP] = 1'b1;
               end else begin
                  if (delay_cnt_r != 32'hFFFF_FFFF) delay_cnt_nxt = delay_cnt_r + 32'h0000_0001;
                  // Only the part above the threshold heats toward trip
                  if (thr_above) inv_acc_nxt = inv_acc_r + 48'(excess[41:0]);
               end
            end
            utp_pkg::UTP_TRIPPED: begin
               if (!(thr_hold && ratio_hold)) begin
                  state_nxt = utp_pkg::UTP_IDLE;
                  events[`UTP_INT_DROPOUT] = 1'b1;
               end
            end
            default: begin
               state_nxt = utp_pkg::UTP_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ctrl_r <= `UTP_RST_CTRL;
         pickup_thr_r <= `UTP_RST_PICKUP;
         ratio_r <= `UTP_RST_RATIO;
         fixed_delay_r <= `UTP_RST_FIXED_DELAY;
         k_r <= `UTP_RST_K;
         scale_r <= `UTP_RST_SCALE;
         decay_r <= `UTP_RST_DECAY;
         theta_max_r <= `UTP_RST_THETA_MAX;
         int_status_r <= 3'h0;
         int_mask_r <= 3'h0;
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
         cmd_reset_r <= 1'b0;
         i2sq_r <= '0;
         i1sq_r <= '0;
         meas_valid_r <= 1'b0;
         state_r <= utp_pkg::UTP_IDLE;
         delay_cnt_r <= 32'h0000_0000;
         inv_acc_r <= '0;
      end else begin
         ctrl_r <= ctrl_nxt;
         pickup_thr_r <= pickup_thr_nxt;
         ratio_r <= ratio_nxt;
         fixed_delay_r <= fixed_delay_nxt;
         k_r <= k_nxt;
         scale_r <= scale_nxt;
         decay_r <= decay_nxt;
         theta_max_r <= theta_max_nxt;
         int_status_r <= int_status_nxt;
         int_mask_r <= int_mask_nxt;
         prdata_r <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
         cmd_reset_r <= cmd_reset_nxt;
         i2sq_r <= i2sq_nxt;
         i1sq_r <= i1sq_nxt;
         meas_valid_r <= meas_valid_nxt;
         state_r <= state_nxt;
         delay_cnt_r <= delay_cnt_nxt;
         inv_acc_r <= inv_acc_nxt;
      end
   end

endmodule : utp_top

// ### testbench/utp_asserts.sv
`include "utp_map.svh"

module utp_asserts (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sample_valid,
   input wire logic pickup,
   input wire logic trip,
   input wire logic prot_reset_pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   sequence s_cmd_wr;
      psel && penable && pwrite && paddr == `UTP_OFF_CMD && pwdata[0];
   endsequence
   // Clear lands one edge after the pulse, so no sample may sit in between
   sequence s_cmd_done;
      prot_reset_pulse ##1 (!pickup && !trip);
   endsequence

   a_cmd_reset: assert property (s_cmd_wr |=> s_cmd_done)
      else $error("reset command did not clear element");
   a_pulse_single: assert property (prot_reset_pulse |=> !prot_reset_pulse)
      else $error("reset pulse longer than one cycle");
   a_trip_pickup: assert property (trip |-> pickup)
      else $error("trip without pickup");
   a_trip_cause: assert property ($rose(trip) |-> $past(sample_valid, 2))
      else $error("trip rose without a sample");
   a_pickup_cause: assert property ($changed(pickup) |-> $past(sample_valid, 2) || $past(prot_reset_pulse))
      else $error("pickup changed without cause");
   a_trip_holds: assert property ($fell(trip) |-> !pickup)
      else $error("trip released while picked up");
   a_pready_high: assert property (pready)
      else $error("wait state inserted");
   a_unmapped_err: assert property (psel && penable && !pwrite && paddr > `UTP_OFF_CMD |-> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped read not refused");
endmodule : utp_asserts

bind utp_top utp_asserts u_utp_asserts (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sample_valid(sample_valid), .pickup(pickup), .trip(trip), .prot_reset_pulse(prot_reset_pulse));

// ### testbench/utp_meas_model.sv
module utp_meas_model (
   input wire logic clk_sys,
   input wire logic en,
   input wire logic [15:0] mag,
   input wire logic [2:0] live,
   output logic sample_valid,
   output logic signed [15:0] a_re,
   output logic signed [15:0] a_im,
   output logic signed [15:0] b_re,
   output logic signed [15:0] b_im,
   output logic signed [15:0] c_re,
   output logic signed [15:0] c_im
);
   timeunit 1ns;
   timeprecision 1ps;
   integer seed = 99;
   int gap = 0;
   int m;
   int s;
   initial {sample_valid, a_re, a_im, b_re, b_im, c_re, c_im} = '0;
   // Balanced ABC set; random gaps give prompt and slow sample rates
   always @(posedge clk_sys) begin
      m = int'(mag);
      s = m * 866 / 1000;
      if (en && gap == 0) begin
         sample_valid <= 1'b1;
         a_re <= live[0] ? 16'(m) : 16'h0000;
         a_im <= 16'h0000;
         b_re <= live[1] ? 16'(-m / 2) : 16'h0000;
         b_im <= live[1] ? 16'(-s) : 16'h0000;
         c_re <= live[2] ? 16'(-m / 2) : 16'h0000;
         c_im <= live[2] ? 16'(s) : 16'h0000;
         gap <= $random(seed) & 3;
      end else begin
         sample_valid <= 1'b0;
         // Toggle between samples so stale phasors never look valid
         {a_re, a_im, b_re, b_im, c_re, c_im} <= ~{a_re, a_im, b_re, b_im, c_re, c_im};
         if (gap > 0) gap <= gap - 1;
      end
   end
endmodule : utp_meas_model

// ### testbench/utp_top_tb.sv
module utp_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic pready, pslverr, sample_valid, pickup, trip, prot_reset_pulse, irq;
   logic signed [15:0] a_re, a_im, b_re, b_im, c_re, c_im;
   logic en = 1'b0;
   logic [15:0] mag = 16'h0000;
   logic [2:0] live = 3'b111;
   logic [32:0] exp_q[$];
   logic [32:0] note;
   int fail_count = 0;
   int tests_run = 0;
   logic [11:0] offs [11] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018, 12'h01C,
      12'h020, 12'h024, 12'h02C};
   logic [31:0] rstv [11] = '{32'h0000_0000, 32'h0000_0100, 32'h0000_0002, 32'h0000_1000, 32'h0001_0000,
      32'h0000_0100, 32'h0000_FF00, 32'h0001_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

   always #2 clk_sys = ~clk_sys;

   utp_top u_utp_top (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sample_valid(sample_valid), .ph_a_re(a_re), .ph_a_im(a_im), .ph_b_re(b_re), .ph_b_im(b_im),
      .ph_c_re(c_re), .ph_c_im(c_im), .pickup(pickup), .trip(trip), .prot_reset_pulse(prot_reset_pulse),
      .irq(irq));
   utp_meas_model u_utp_meas_model (.clk_sys(clk_sys), .en(en), .mag(mag), .live(live),
      .sample_valid(sample_valid), .a_re(a_re), .a_im(a_im), .b_re(b_re), .b_im(b_im), .c_re(c_re),
      .c_im(c_im));

   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge so the next setup never reassigns psel in this step
      @(posedge clk_sys);
   endtask : xfer

   task automatic rd(input logic [11:0] a, input logic [31:0] v, input logic e = 1'b0);
      exp_q.push_back({e, v});
      xfer(1'b0, a, 32'h0000_0000);
   endtask : rd

   task automatic chk_irq(input logic e);
      #1;
      tests_run++;
      if (irq !== e) begin
         fail_count++;
         $display("mismatch at %0t: irq %b", $time, irq);
      end
      @(posedge clk_sys);
   endtask : chk_irq

   task automatic ws(input int n);
      repeat (n) @(posedge clk_sys iff sample_valid === 1'b1);
      repeat (3) @(posedge clk_sys);
   endtask : ws

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : report_and_stop

   always @(posedge clk_sys) begin
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
         note = exp_q.pop_front();
         tests_run++;
         if ({pslverr, prdata} !== note) begin
            fail_count++;
            $display("mismatch at %0t: addr %h read %h expected %h", $time, paddr, {pslverr, prdata}, note);
         end
      end
   end

   initial begin
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      for (int i = 0; i < 11; i++) rd(offs[i], rstv[i]);
      xfer(1'b1, 12'h020, 32'h0000_0007);
      rd(12'h020, 32'h0000_0000);
      rd(12'h030, 32'h0000_0000, 1'b1);
      $display("test registers done");
      xfer(1'b1, 12'h028, 32'h0000_0007);
      rd(12'h028, 32'h0000_0007);
      xfer(1'b1, 12'h00C, 32'h0000_0008);
      mag <= 16'h03E8;
      en <= 1'b1;
      ws(6);
      rd(12'h020, 32'h0000_0000);
      xfer(1'b1, 12'h000, 32'h0000_0004);
      ws(4);
      rd(12'h020, 32'h0000_0005);
      ws(8);
      rd(12'h020, 32'h0000_0007);
      chk_irq(1'b1);
      rd(12'h024, 32'h0000_0003);
      chk_irq(1'b0);
      $display("test rotation and delay done");
      live <= 3'b001;
      mag <= 16'h0384;
      xfer(1'b1, 12'h000, 32'h0000_0001);
      ws(3);
      rd(12'h020, 32'h0000_0007);
      mag <= 16'h02EE;
      ws(3);
      rd(12'h020, 32'h0000_0003);
      mag <= 16'h02E8;
      ws(3);
      rd(12'h020, 32'h0000_0000);
      chk_irq(1'b1);
      rd(12'h024, 32'h0000_0004);
      $display("test hysteresis done");
      mag <= 16'h0384;
      ws(12);
      rd(12'h020, 32'h0000_0007);
      en <= 1'b0;
      repeat (4) @(posedge clk_sys);
      xfer(1'b1, 12'h02C, 32'h0000_0001);
      // Level inside the hysteresis band would hold an uncleared pickup
      mag <= 16'h02EE;
      en <= 1'b1;
      ws(3);
      rd(12'h020, 32'h0000_0000);
      $display("test reset command done");
      live <= 3'b110;
      mag <= 16'h03E8;
      xfer(1'b1, 12'h000, 32'h0000_0000);
      xfer(1'b1, 12'h004, 32'h0000_0158);
      ws(4);
      rd(12'h020, 32'h0000_0000);
      xfer(1'b1, 12'h004, 32'h0000_0140);
      ws(4);
      rd(12'h020, 32'h0000_0005);
      $display("test lost phase done");
      // Cold curve: no heat, long fixed delay so only the curve can trip
      live <= 3'b111;
      xfer(1'b1, 12'h014, 32'h0000_0000);
      xfer(1'b1, 12'h01C, 32'h0000_0010);
      xfer(1'b1, 12'h00C, 32'h0000_0100);
      xfer(1'b1, 12'h010, 32'h0000_0100);
      xfer(1'b1, 12'h02C, 32'h0000_0001);
      xfer(1'b1, 12'h000, 32'h0000_0006);
      ws(8);
      rd(12'h020, 32'h0000_0005);
      ws(16);
      rd(12'h020, 32'h0000_0007);
      // Heat hard while tripped, cool briefly, rerun with no added heat
      xfer(1'b1, 12'h014, 32'h0000_FFFF);
      ws(12);
      mag <= 16'h0000;
      ws(2);
      rd(12'h020, 32'h0000_0000);
      mag <= 16'h03E8;
      xfer(1'b1, 12'h014, 32'h0000_0000);
      // Cold would need about twice the samples this window allows
      ws(10);
      rd(12'h020, 32'h0000_0007);
      $display("test inverse curve done");
      report_and_stop();
   end

   initial begin
      #60000;
      fail_count++;
      report_and_stop();
   end
endmodule : utp_top_tb
